// File: rtl/dbp_param_pair.sv
// shadow and active copy of one double-buffered parameter
`timescale 1ns/1ns
`default_nettype none
module dbp_param_pair
#(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic write_i,
  input wire logic [WIDTH-1:0] write_data_i,
  input wire logic [WIDTH/8-1:0] write_strb_i,
  input wire logic commit_i,
  output logic [WIDTH-1:0] shadow_o,
  output logic [WIDTH-1:0] active_o
);
  if (WIDTH % 8 != 0 || WIDTH < 8)
  begin : g_width_check
    $error("dbp_param_pair: WIDTH must be a positive multiple of 8");
  end

  genvar b;
  for (b = 0; b < WIDTH / 8; b++)
  begin : g_byte
    // one shadow and one active register per lane, so no variable has two writers
    logic [7:0] shadow_r;
    logic [7:0] active_r;

    always_ff @(posedge ref_clk_i)
    begin
      if (!reset_n_i)
        shadow_r <= RESET_VALUE[8*b +: 8];
      else if (write_i && write_strb_i[b])
        shadow_r <= write_data_i[8*b +: 8];
    end

    always_ff @(posedge ref_clk_i)
    begin
      if (!reset_n_i)
        active_r <= RESET_VALUE[8*b +: 8];
      else if (commit_i)
        active_r <= shadow_r;
    end

    assign shadow_o[8*b +: 8] = shadow_r;
    assign active_o[8*b +: 8] = active_r;
  end
endmodule // dbp_param_pair
`default_nettype wire

// File: rtl/dbp_pkg.sv
// constants of the double-buffered parameter register bank
//
// Behaviour
// - keep shadow and active copies of parameters
// - writes to the frame size and filter strength registers land in shadow immediately
// - start of frame copies shadow into active
// - copy happens only while commit flag is one
package dbp_pkg;
  localparam int REG_ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;

  localparam logic [REG_ADDR_W-1:0] OFS_CORE_CONTROL = 9'h000;
  localparam logic [REG_ADDR_W-1:0] OFS_CORE_STATUS = 9'h004;
  localparam logic [REG_ADDR_W-1:0] OFS_ERROR_FLAGS = 9'h008;
  localparam logic [REG_ADDR_W-1:0] OFS_IRQ_ENABLE_MASK = 9'h00c;
  localparam logic [REG_ADDR_W-1:0] OFS_CORE_VERSION = 9'h010;
  localparam logic [REG_ADDR_W-1:0] OFS_FRAME_COUNT_MON = 9'h014;
  localparam logic [REG_ADDR_W-1:0] OFS_LINE_COUNT_MON = 9'h018;
  localparam logic [REG_ADDR_W-1:0] OFS_PIXEL_COUNT_MON = 9'h01c;
  localparam logic [REG_ADDR_W-1:0] OFS_ACTIVE_FRAME_SIZE = 9'h020;
  localparam logic [REG_ADDR_W-1:0] OFS_FILTER_STRENGTH = 9'h100;

  // core_control fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_COMMIT_BIT = 1;
  localparam logic [DATA_W-1:0] CTRL_MASK = 32'h0000_0003;
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] IRQ_MASK_RST = 32'h0000_0000;

  // core_status fields
  localparam int STAT_PENDING_BIT = 0;

  // reset values of the double-buffered parameters
  localparam logic [DATA_W-1:0] FRAME_SIZE_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] FILTER_STRENGTH_RST = 32'h0000_0000;

  // arbitrary identification value
  localparam logic [DATA_W-1:0] VERSION_RST = 32'h0001_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: rtl/dbp_regs.sv
// axi4-lite register bank with double-buffered frame parameters
`timescale 1ns/1ns
`default_nettype none
module dbp_regs
#(
  parameter logic [dbp_pkg::DATA_W-1:0] VERSION_ID = dbp_pkg::VERSION_RST
)
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [dbp_pkg::REG_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [dbp_pkg::DATA_W-1:0] s_axi_wdata_i,
  input wire logic [dbp_pkg::STRB_W-1:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [dbp_pkg::REG_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [dbp_pkg::DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic s_axis_video_tvalid_i,
  input wire logic s_axis_video_tready_i,
  input wire logic s_axis_video_tuser_i,
  input wire logic [dbp_pkg::DATA_W-1:0] error_flags_i,
  input wire logic [dbp_pkg::DATA_W-1:0] frame_count_i,
  input wire logic [dbp_pkg::DATA_W-1:0] line_count_i,
  input wire logic [dbp_pkg::DATA_W-1:0] pixel_count_i,
  output logic core_enable_o,
  output logic commit_enable_flag_o,
  output logic [dbp_pkg::DATA_W-1:0] interrupt_enable_mask_o,
  output logic [dbp_pkg::DATA_W-1:0] active_frame_size_o,
  output logic [dbp_pkg::DATA_W-1:0] filter_strength_o,
  output logic update_pending_o
);
  import dbp_pkg::*;

  logic [DATA_W-1:0] core_control_r;
  logic [DATA_W-1:0] interrupt_enable_mask_r;
  logic update_pending_r;
  logic aw_ready_r;
  logic ar_ready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic rerr_nxt;
  logic werr_nxt;
  logic [DATA_W-1:0] frame_size_shadow;
  logic [DATA_W-1:0] filter_strength_shadow;
  logic wr_fire;
  logic rd_fire;
  logic sof_beat;
  logic commit;
  logic wr_frame_size;
  logic wr_filter_strength;

  // merge write data into a register under byte strobes
  function automatic logic [DATA_W-1:0] strb_merge(
    input logic [DATA_W-1:0] old_val,
    input logic [DATA_W-1:0] new_val,
    input logic [STRB_W-1:0] strb
  );
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int i = 0; i < STRB_W; i++)
    begin
      if (strb[i])
        res[8*i +: 8] = new_val[8*i +: 8];
    end
    return res;
  endfunction

  assign wr_fire = s_axi_awvalid_i && s_axi_wvalid_i && aw_ready_r;
  assign rd_fire = s_axi_arvalid_i && ar_ready_r;
  assign wr_frame_size = wr_fire && (s_axi_awaddr_i == OFS_ACTIVE_FRAME_SIZE);
  assign wr_filter_strength = wr_fire && (s_axi_awaddr_i == OFS_FILTER_STRENGTH);

  // one start of frame per accepted beat with tuser set
  assign sof_beat = s_axis_video_tvalid_i && s_axis_video_tready_i && s_axis_video_tuser_i;
  assign commit = sof_beat && core_control_r[CTRL_COMMIT_BIT];

  // write channel: address and data taken together
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      aw_ready_r <= 1'b0;
    else if (wr_fire)
      aw_ready_r <= 1'b0;
    else
      aw_ready_r <= s_axi_awvalid_i && s_axi_wvalid_i && !bvalid_r;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= werr_nxt ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_bready_i)
      bvalid_r <= 1'b0;
  end

  always_comb
  begin
    case (s_axi_awaddr_i)
      OFS_CORE_CONTROL, OFS_CORE_STATUS, OFS_ERROR_FLAGS, OFS_IRQ_ENABLE_MASK,
      OFS_CORE_VERSION, OFS_FRAME_COUNT_MON, OFS_LINE_COUNT_MON, OFS_PIXEL_COUNT_MON,
      OFS_ACTIVE_FRAME_SIZE, OFS_FILTER_STRENGTH: werr_nxt = 1'b0;
      default: werr_nxt = 1'b1;
    endcase
  end

  // software-writable control state
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      core_control_r <= CTRL_RST;
    else if (wr_fire && s_axi_awaddr_i == OFS_CORE_CONTROL)
      core_control_r <= strb_merge(core_control_r, s_axi_wdata_i, s_axi_wstrb_i) & CTRL_MASK;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      interrupt_enable_mask_r <= IRQ_MASK_RST;
    else if (wr_fire && s_axi_awaddr_i == OFS_IRQ_ENABLE_MASK)
      interrupt_enable_mask_r <= strb_merge(interrupt_enable_mask_r, s_axi_wdata_i, s_axi_wstrb_i);
  end

  // pending: a shadow write not yet committed; a new write beats the commit
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      update_pending_r <= 1'b0;
    else if (wr_frame_size || wr_filter_strength)
      update_pending_r <= 1'b1;
    else if (commit)
      update_pending_r <= 1'b0;
  end

  dbp_param_pair
  #(
    .WIDTH(DATA_W),
    .RESET_VALUE(FRAME_SIZE_RST)
  )
  u_frame_size
  (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .write_i(wr_frame_size),
    .write_data_i(s_axi_wdata_i),
    .write_strb_i(s_axi_wstrb_i),
    .commit_i(commit),
    .shadow_o(frame_size_shadow),
    .active_o(active_frame_size_o)
  );

  dbp_param_pair
  #(
    .WIDTH(DATA_W),
    .RESET_VALUE(FILTER_STRENGTH_RST)
  )
  u_filter_strength
  (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .write_i(wr_filter_strength),
    .write_data_i(s_axi_wdata_i),
    .write_strb_i(s_axi_wstrb_i),
    .commit_i(commit),
    .shadow_o(filter_strength_shadow),
    .active_o(filter_strength_o)
  );

  // read channel
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      ar_ready_r <= 1'b0;
    else if (rd_fire)
      ar_ready_r <= 1'b0;
    else
      ar_ready_r <= s_axi_arvalid_i && !rvalid_r;
  end

  always_comb
  begin
    rdata_nxt = '0;
    rerr_nxt = 1'b0;
    case (s_axi_araddr_i)
      OFS_CORE_CONTROL: rdata_nxt = core_control_r;
      OFS_CORE_STATUS: rdata_nxt[STAT_PENDING_BIT] = update_pending_r;
      OFS_ERROR_FLAGS: rdata_nxt = error_flags_i;
      OFS_IRQ_ENABLE_MASK: rdata_nxt = interrupt_enable_mask_r;
      OFS_CORE_VERSION: rdata_nxt = VERSION_ID;
      OFS_FRAME_COUNT_MON: rdata_nxt = frame_count_i;
      OFS_LINE_COUNT_MON: rdata_nxt = line_count_i;
      OFS_PIXEL_COUNT_MON: rdata_nxt = pixel_count_i;
      OFS_ACTIVE_FRAME_SIZE: rdata_nxt = frame_size_shadow;
      OFS_FILTER_STRENGTH: rdata_nxt = filter_strength_shadow;
      default: rerr_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
    end
    else if (rd_fire)
    begin
      rvalid_r <= 1'b1;
      rresp_r <= rerr_nxt ? RESP_SLVERR : RESP_OKAY;
      rdata_r <= rdata_nxt;
    end
    else if (s_axi_rready_i)
      rvalid_r <= 1'b0;
  end

  assign s_axi_awready_o = aw_ready_r;
  assign s_axi_wready_o = aw_ready_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = ar_ready_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rresp_o = rresp_r;
  assign s_axi_rdata_o = rdata_r;
  assign core_enable_o = core_control_r[CTRL_ENABLE_BIT];
  assign commit_enable_flag_o = core_control_r[CTRL_COMMIT_BIT];
  assign interrupt_enable_mask_o = interrupt_enable_mask_r;
  assign update_pending_o = update_pending_r;
endmodule // dbp_regs
`default_nettype wire

// File: sim/dbp_regs_properties.sv
// port-level assertions of the double-buffered parameter bank
`timescale 1ns/1ns
`default_nettype none
module dbp_regs_checker
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axis_video_tvalid_i,
  input wire logic s_axis_video_tready_i,
  input wire logic s_axis_video_tuser_i,
  input wire logic commit_enable_flag_o,
  input wire logic [dbp_pkg::DATA_W-1:0] active_frame_size_o,
  input wire logic [dbp_pkg::DATA_W-1:0] filter_strength_o,
  input wire logic update_pending_o
);
  import dbp_pkg::*;
  wire logic sof;
  assign sof = s_axis_video_tvalid_i && s_axis_video_tready_i && s_axis_video_tuser_i;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  a_hold_no_commit: assert property (
    !(sof && commit_enable_flag_o) |=> $stable(active_frame_size_o) && $stable(filter_strength_o))
    else $error("active copy moved without committing frame start");
  a_commit_clears_pending: assert property (
    sof && commit_enable_flag_o && !s_axi_awready_o |=> !update_pending_o)
    else $error("pending still set after commit");
  a_pending_by_write: assert property (
    $rose(update_pending_o) |-> $past(s_axi_awready_o))
    else $error("pending set without a register write");
  a_pending_kept: assert property (
    update_pending_o && !(sof && commit_enable_flag_o) |=> update_pending_o)
    else $error("pending lost without commit");
  a_size_cause: assert property (
    !$stable(active_frame_size_o) |-> $past(sof && commit_enable_flag_o))
    else $error("frame size changed outside a commit");
  a_filter_cause: assert property (
    !$stable(filter_strength_o) |-> $past(sof && commit_enable_flag_o))
    else $error("filter strength changed outside a commit");
endmodule // dbp_regs_checker
`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench of the double-buffered parameter bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dbp_pkg::*;
  logic ref_clk_i = 0, reset_n_i = 0;
  logic [REG_ADDR_W-1:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [31:0] s_axi_wdata_i = '0, error_flags_i = 32'h0000_00e1, frame_count_i = 32'h0000_0f14;
  logic [31:0] line_count_i = 32'h0001_2318, pixel_count_i = 32'h00ab_cd1c;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0;
  logic s_axis_video_tvalid_i = 0, s_axis_video_tready_i = 0, s_axis_video_tuser_i = 0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic core_enable_o, commit_enable_flag_o, update_pending_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o, interrupt_enable_mask_o, active_frame_size_o, filter_strength_o;
  int n_errors = 0, compares = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  dbp_regs uut (.ref_clk_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .s_axis_video_tvalid_i, .s_axis_video_tready_i, .s_axis_video_tuser_i, .error_flags_i,
    .frame_count_i, .line_count_i, .pixel_count_i, .core_enable_o, .commit_enable_flag_o,
    .interrupt_enable_mask_o, .active_frame_size_o, .filter_strength_o, .update_pending_o);
  task automatic chk(input string what, input logic [34:0] exp, input logic [34:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d, input logic [1:0] rsp);
    int n;
    n = 0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (!s_axi_awready_o && n < 20);
    chk("write ready", 35'h1, {34'h0, s_axi_wready_o});
    s_axi_awvalid_i <= 0;
    s_axi_wvalid_i <= 0;
    s_axi_bready_i <= 1;
    @(posedge ref_clk_i);
    chk("write response", {1'b1, rsp, 32'h0}, {s_axi_bvalid_o, s_axi_bresp_o, 32'h0});
    s_axi_bready_i <= 0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] d, input logic [1:0] rsp);
    int n;
    n = 0;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (!s_axi_arready_o && n < 20);
    s_axi_arvalid_i <= 0;
    s_axi_rready_i <= 1;
    @(posedge ref_clk_i);
    chk("read response", {1'b1, rsp, d}, {s_axi_rvalid_o, s_axi_rresp_o, s_axi_rdata_o});
    s_axi_rready_i <= 0;
  endtask
  // one stream beat with the given valid, ready, user levels
  task automatic beat(input logic [2:0] vru);
    {s_axis_video_tvalid_i, s_axis_video_tready_i, s_axis_video_tuser_i} <= vru;
    @(posedge ref_clk_i);
    {s_axis_video_tvalid_i, s_axis_video_tready_i, s_axis_video_tuser_i} <= 3'h0;
    @(posedge ref_clk_i);
  endtask
  initial
  begin
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1;
    @(posedge ref_clk_i);
    rd(OFS_CORE_CONTROL, CTRL_RST, RESP_OKAY);
    rd(OFS_CORE_VERSION, VERSION_RST, RESP_OKAY);
    rd(9'h024, 32'h0, RESP_SLVERR);
    $display("test reset done");
    wr(OFS_ACTIVE_FRAME_SIZE, 32'h0438_0780, RESP_OKAY);
    wr(OFS_FILTER_STRENGTH, 32'h0000_0005, RESP_OKAY);
    rd(OFS_ACTIVE_FRAME_SIZE, 32'h0438_0780, RESP_OKAY);
    rd(OFS_CORE_STATUS, 32'h1, RESP_OKAY);
    beat(3'b111);
    chk("active size", {3'h0, FRAME_SIZE_RST}, {3'h0, active_frame_size_o});
    $display("test hold done");
    wr(OFS_CORE_CONTROL, 32'hffff_fffe, RESP_OKAY);
    rd(OFS_CORE_CONTROL, 32'h2, RESP_OKAY);
    chk("enable", 35'h0, {34'h0, core_enable_o});
    chk("commit flag", 35'h1, {34'h0, commit_enable_flag_o});
    for (int i = 0; i < 3; i++)
    begin
      beat(3'b111 ^ (3'b001 << i));
      chk("active filter", {3'h0, FILTER_STRENGTH_RST}, {3'h0, filter_strength_o});
    end
    beat(3'b111);
    chk("active size", {3'h0, 32'h0438_0780}, {3'h0, active_frame_size_o});
    chk("active filter", 35'h5, {3'h0, filter_strength_o});
    chk("pending", 35'h0, {34'h0, update_pending_o});
    s_axi_wstrb_i <= 4'h1;
    wr(OFS_FILTER_STRENGTH, 32'hffff_ff0a, RESP_OKAY);
    s_axi_wstrb_i <= 4'hf;
    rd(OFS_FILTER_STRENGTH, 32'h0000_000a, RESP_OKAY);
    beat(3'b111);
    chk("active filter", 35'ha, {3'h0, filter_strength_o});
    wr(OFS_CORE_CONTROL, 32'h0000_0003, RESP_OKAY);
    chk("enable", 35'h1, {34'h0, core_enable_o});
    chk("commit flag", 35'h1, {34'h0, commit_enable_flag_o});
    $display("test commit done");
    wr(OFS_CORE_VERSION, 32'h0, RESP_OKAY);
    wr(9'h024, 32'h1, RESP_SLVERR);
    wr(OFS_IRQ_ENABLE_MASK, 32'h0000_00a5, RESP_OKAY);
    chk("irq mask", 35'ha5, {3'h0, interrupt_enable_mask_o});
    rd(OFS_CORE_VERSION, VERSION_RST, RESP_OKAY);
    rd(OFS_ERROR_FLAGS, 32'h0000_00e1, RESP_OKAY);
    rd(OFS_FRAME_COUNT_MON, 32'h0000_0f14, RESP_OKAY);
    rd(OFS_LINE_COUNT_MON, 32'h0001_2318, RESP_OKAY);
    rd(OFS_PIXEL_COUNT_MON, 32'h00ab_cd1c, RESP_OKAY);
    $display("test map done");
    conclude();
  end
  initial
  begin
    repeat (2000) @(posedge ref_clk_i);
    n_errors++;
    conclude();
  end
endmodule // tb_top
bind dbp_regs dbp_regs_checker u_chk (.ref_clk_i, .reset_n_i, .s_axi_awready_o, .s_axis_video_tvalid_i,
  .s_axis_video_tready_i, .s_axis_video_tuser_i, .commit_enable_flag_o, .active_frame_size_o,
  .filter_strength_o, .update_pending_o);
`default_nettype wire
